// ==== crs_consts.svh ====
// Behaviour
// - call fetches opcode, high, low target bytes
// - one internal cycle builds 16-bit target
// - first push: return low byte, decrement stack
// - second push: return high byte, decrement again
// - saved address follows the three-byte call
// - next cycle fetches subroutine's first opcode
// - decrement takes three cycles, accumulator minus one
// - taken branch adds signed offset to counter
// - zero result: branch falls through
// - return takes six cycles from opcode fetch
// - return pops high, then low, loads counter
// - direct store: fetch, address, build, write
// - direct address high byte is zero
// - immediate load: opcode, then data byte
// - load touches only negative and zero flags
// - zero flag on 00, negative is msb
//
`ifndef CRS_CONSTS_SVH
`define CRS_CONSTS_SVH

// opcodes
`define CRS_OP_LOAD_IMM   8'ha6
`define CRS_OP_STORE_DIR  8'hb7
`define CRS_OP_CALL_ABS   8'hcd
`define CRS_OP_DEC_ACC    8'h4a
`define CRS_OP_BR_NZ      8'h26
`define CRS_OP_RETURN     8'h81

// address pages
`define CRS_DIRECT_PAGE   8'h00
`define CRS_STACK_PAGE    8'h00

// reset values
`define CRS_RST_PC        16'h0100
`define CRS_RST_SP        8'hff
`define CRS_RST_ACC       8'h00
`define CRS_RST_FLAGS     5'h00

// condition flag bit positions (h i n z c)
`define CRS_FLAG_H        4
`define CRS_FLAG_I        3
`define CRS_FLAG_N        2
`define CRS_FLAG_Z        1
`define CRS_FLAG_C        0

`endif

// ==== crs_pkg.sv ====
`default_nettype none

package crs_pkg;

  typedef enum logic [4:0] {
    ST_FETCH,
    ST_LOAD_DATA,
    ST_STORE_ADDR,
    ST_STORE_FORM,
    ST_STORE_WRITE,
    ST_CALL_HI,
    ST_CALL_LO,
    ST_CALL_FORM,
    ST_CALLR_OFS,
    ST_CALLR_FORM,
    ST_PUSH_LO,
    ST_PUSH_HI,
    ST_DEC_1,
    ST_DEC_2,
    ST_BR_OFS,
    ST_BR_EXEC,
    ST_RET_INC1,
    ST_RET_RD_HI,
    ST_RET_INC2,
    ST_RET_RD_LO,
    ST_RET_LOAD
  } crs_state_t;

endpackage : crs_pkg

`default_nettype wire

// ==== crs_rel_adder.sv ====
`timescale 1ns/1ps
`default_nettype none

// program counter plus signed byte offset
module crs_rel_adder (
  input  wire logic [15:0] base_i,
  input  wire logic [7:0]  offset_i,
  output logic      [15:0] sum_o
);

  // sign extend, wrap within 16 bits
  assign sum_o = base_i + {{8{offset_i[7]}}, offset_i};

endmodule : crs_rel_adder

`default_nettype wire

// ==== crs_nz_flags.sv ====
`timescale 1ns/1ps
`default_nettype none

// negative and zero of a result byte
module crs_nz_flags (
  input  wire logic [7:0] value_i,
  output logic            neg_o,
  output logic            zero_o
);

  assign neg_o  = value_i[7];
  assign zero_o = (value_i == 8'h00);

endmodule : crs_nz_flags

`default_nettype wire

// ==== crs_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "crs_consts.svh"

module crs_sequencer #(
  parameter logic [7:0] OP_CALL_REL = 8'had  // opcode of the relative call
) (
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  input  wire logic [7:0]  MEM_RDATA_I,
  output logic      [15:0] MEM_ADDR_O,
  output logic      [7:0]  MEM_WDATA_O,
  output logic             MEM_WE_O,
  output logic             MEM_RE_O,
  output logic             SYNC_O,
  output logic      [15:0] PC_O,
  output logic      [7:0]  SP_O,
  output logic      [7:0]  ACC_O,
  output logic      [4:0]  FLAGS_O
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  crs_pkg::crs_state_t state_ff;
  crs_pkg::crs_state_t nxt_state;
  logic [15:0] pc_ff;
  logic [15:0] nxt_pc;
  logic [7:0]  sp_ff;
  logic [7:0]  nxt_sp;
  logic [7:0]  acc_ff;
  logic [7:0]  nxt_acc;
  logic [4:0]  flags_ff;
  logic [4:0]  nxt_flags;
  logic [15:0] tgt_ff;
  logic [15:0] nxt_tgt;
  logic [7:0]  ofs_ff;
  logic [7:0]  nxt_ofs;
  logic [7:0]  ea_ff;
  logic [7:0]  nxt_ea;

  logic [15:0] addr_ff;
  logic [15:0] nxt_addr;
  logic [7:0]  wdata_ff;
  logic [7:0]  nxt_wdata;
  logic        we_ff;
  logic        nxt_we;
  logic        re_ff;
  logic        nxt_re;
  logic        sync_ff;
  logic        nxt_sync;

  logic [15:0] rel_sum;
  logic [7:0]  dec_val;
  logic [7:0]  nz_src;
  logic        nz_neg;
  logic        nz_zero;

  ////////////////////////////////////////////////////////////////////////////
  // shared datapath pieces

  // one adder serves both relative call and branch, they never overlap
  crs_rel_adder u_rel_adder (
    .base_i   (pc_ff),
    .offset_i (ofs_ff),
    .sum_o    (rel_sum)
  );

  assign dec_val = acc_ff - 8'h01;

  // flag source: loaded byte or decremented accumulator
  assign nz_src = (state_ff == crs_pkg::ST_LOAD_DATA) ? MEM_RDATA_I : dec_val;

  crs_nz_flags u_nz_flags (
    .value_i (nz_src),
    .neg_o   (nz_neg),
    .zero_o  (nz_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencing and register next values

  always_comb begin
    nxt_state = state_ff;
    nxt_pc    = pc_ff;
    nxt_sp    = sp_ff;
    nxt_acc   = acc_ff;
    nxt_flags = flags_ff;
    nxt_tgt   = tgt_ff;
    nxt_ofs   = ofs_ff;
    nxt_ea    = ea_ff;
    case (state_ff)
      crs_pkg::ST_FETCH: begin
        nxt_pc = pc_ff + 16'h0001;
        case (MEM_RDATA_I)
          `CRS_OP_LOAD_IMM:  nxt_state = crs_pkg::ST_LOAD_DATA;
          `CRS_OP_STORE_DIR: nxt_state = crs_pkg::ST_STORE_ADDR;
          `CRS_OP_CALL_ABS:  nxt_state = crs_pkg::ST_CALL_HI;
          OP_CALL_REL:       nxt_state = crs_pkg::ST_CALLR_OFS;
          `CRS_OP_DEC_ACC:   nxt_state = crs_pkg::ST_DEC_1;
          `CRS_OP_BR_NZ:     nxt_state = crs_pkg::ST_BR_OFS;
          `CRS_OP_RETURN:    nxt_state = crs_pkg::ST_RET_INC1;
          default:           nxt_state = crs_pkg::ST_FETCH;       // unknown: one-cycle no-op
        endcase
      end
      // immediate load, only n and z change
      crs_pkg::ST_LOAD_DATA: begin
        nxt_acc                  = MEM_RDATA_I;
        nxt_flags[`CRS_FLAG_N]   = nz_neg;
        nxt_flags[`CRS_FLAG_Z]   = nz_zero;
        nxt_pc                   = pc_ff + 16'h0001;
        nxt_state                = crs_pkg::ST_FETCH;
      end
      // direct store
      crs_pkg::ST_STORE_ADDR: begin
        nxt_ea    = MEM_RDATA_I;
        nxt_state = crs_pkg::ST_STORE_FORM;
      end
      crs_pkg::ST_STORE_FORM: begin
        nxt_pc    = pc_ff + 16'h0001;                             // pc moves in the build cycle
        nxt_state = crs_pkg::ST_STORE_WRITE;
      end
      crs_pkg::ST_STORE_WRITE: begin
        nxt_state = crs_pkg::ST_FETCH;
      end
      // absolute call operand bytes, high first
      crs_pkg::ST_CALL_HI: begin
        nxt_tgt[15:8] = MEM_RDATA_I;
        nxt_pc        = pc_ff + 16'h0001;
        nxt_state     = crs_pkg::ST_CALL_LO;
      end
      crs_pkg::ST_CALL_LO: begin
        nxt_tgt[7:0] = MEM_RDATA_I;
        nxt_pc       = pc_ff + 16'h0001;
        nxt_state    = crs_pkg::ST_CALL_FORM;
      end
      crs_pkg::ST_CALL_FORM: begin
        nxt_state = crs_pkg::ST_PUSH_LO;
      end
      // relative call
      crs_pkg::ST_CALLR_OFS: begin
        nxt_ofs   = MEM_RDATA_I;
        nxt_pc    = pc_ff + 16'h0001;                             // return address
        nxt_state = crs_pkg::ST_CALLR_FORM;
      end
      crs_pkg::ST_CALLR_FORM: begin
        nxt_tgt   = rel_sum;
        nxt_state = crs_pkg::ST_PUSH_LO;
      end
      // pushes: write at sp, then decrement
      crs_pkg::ST_PUSH_LO: begin
        nxt_sp    = sp_ff - 8'h01;
        nxt_state = crs_pkg::ST_PUSH_HI;
      end
      crs_pkg::ST_PUSH_HI: begin
        nxt_sp    = sp_ff - 8'h01;
        nxt_pc    = tgt_ff;
        nxt_state = crs_pkg::ST_FETCH;
      end
      // decrement accumulator
      crs_pkg::ST_DEC_1: begin
        nxt_acc                = dec_val;
        nxt_flags[`CRS_FLAG_N] = nz_neg;
        nxt_flags[`CRS_FLAG_Z] = nz_zero;
        nxt_state              = crs_pkg::ST_DEC_2;
      end
      crs_pkg::ST_DEC_2: begin
        nxt_state = crs_pkg::ST_FETCH;
      end
      // branch if nonzero
      crs_pkg::ST_BR_OFS: begin
        nxt_ofs   = MEM_RDATA_I;
        nxt_pc    = pc_ff + 16'h0001;                             // past the branch
        nxt_state = crs_pkg::ST_BR_EXEC;
      end
      crs_pkg::ST_BR_EXEC: begin
        if (!flags_ff[`CRS_FLAG_Z]) begin
          nxt_pc = rel_sum;
        end else begin
          nxt_pc = pc_ff;
        end
        nxt_state = crs_pkg::ST_FETCH;
      end
      // return: increment before each pop
      crs_pkg::ST_RET_INC1: begin
        nxt_sp    = sp_ff + 8'h01;
        nxt_state = crs_pkg::ST_RET_RD_HI;
      end
      crs_pkg::ST_RET_RD_HI: begin
        nxt_tgt[15:8] = MEM_RDATA_I;
        nxt_state     = crs_pkg::ST_RET_INC2;
      end
      crs_pkg::ST_RET_INC2: begin
        nxt_sp    = sp_ff + 8'h01;
        nxt_state = crs_pkg::ST_RET_RD_LO;
      end
      crs_pkg::ST_RET_RD_LO: begin
        nxt_tgt[7:0] = MEM_RDATA_I;
        nxt_state    = crs_pkg::ST_RET_LOAD;
      end
      crs_pkg::ST_RET_LOAD: begin
        nxt_pc    = tgt_ff;
        nxt_state = crs_pkg::ST_FETCH;
      end
      default: begin
        nxt_state = crs_pkg::ST_FETCH;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus request for the coming cycle, decided from the next state

  // registered so the bus sees clean flop outputs; data returns same cycle
  always_comb begin
    nxt_addr  = nxt_pc;
    nxt_wdata = 8'h00;
    nxt_we    = 1'b0;
    nxt_re    = 1'b0;
    nxt_sync  = 1'b0;
    case (nxt_state)
      crs_pkg::ST_FETCH: begin
        nxt_re   = 1'b1;
        nxt_sync = 1'b1;
      end
      crs_pkg::ST_LOAD_DATA,
      crs_pkg::ST_STORE_ADDR,
      crs_pkg::ST_CALL_HI,
      crs_pkg::ST_CALL_LO,
      crs_pkg::ST_CALLR_OFS,
      crs_pkg::ST_BR_OFS: begin
        nxt_re = 1'b1;
      end
      crs_pkg::ST_STORE_WRITE: begin
        nxt_addr  = {`CRS_DIRECT_PAGE, nxt_ea};
        nxt_wdata = nxt_acc;
        nxt_we    = 1'b1;
      end
      crs_pkg::ST_PUSH_LO: begin
        nxt_addr  = {`CRS_STACK_PAGE, nxt_sp};
        nxt_wdata = nxt_pc[7:0];
        nxt_we    = 1'b1;
      end
      crs_pkg::ST_PUSH_HI: begin
        nxt_addr  = {`CRS_STACK_PAGE, nxt_sp};
        nxt_wdata = nxt_pc[15:8];
        nxt_we    = 1'b1;
      end
      crs_pkg::ST_RET_RD_HI,
      crs_pkg::ST_RET_RD_LO: begin
        nxt_addr = {`CRS_STACK_PAGE, nxt_sp};
        nxt_re   = 1'b1;
      end
      default: begin
        nxt_re = 1'b0;                                            // internal cycle, bus idle
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_ff <= crs_pkg::ST_FETCH;
      pc_ff    <= `CRS_RST_PC;
      sp_ff    <= `CRS_RST_SP;
      acc_ff   <= `CRS_RST_ACC;
      flags_ff <= `CRS_RST_FLAGS;
      tgt_ff   <= 16'h0000;
      ofs_ff   <= 8'h00;
      ea_ff    <= 8'h00;
      addr_ff  <= `CRS_RST_PC;   // first fetch already on the bus
      wdata_ff <= 8'h00;
      we_ff    <= 1'b0;
      re_ff    <= 1'b1;
      sync_ff  <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      pc_ff    <= nxt_pc;
      sp_ff    <= nxt_sp;
      acc_ff   <= nxt_acc;
      flags_ff <= nxt_flags;
      tgt_ff   <= nxt_tgt;
      ofs_ff   <= nxt_ofs;
      ea_ff    <= nxt_ea;
      addr_ff  <= nxt_addr;
      wdata_ff <= nxt_wdata;
      we_ff    <= nxt_we;
      re_ff    <= nxt_re;
      sync_ff  <= nxt_sync;
    end
  end

  assign MEM_ADDR_O  = addr_ff;
  assign MEM_WDATA_O = wdata_ff;
  assign MEM_WE_O    = we_ff;
  assign MEM_RE_O    = re_ff;
  assign SYNC_O      = sync_ff;
  assign PC_O        = pc_ff;
  assign SP_O        = sp_ff;
  assign ACC_O       = acc_ff;
  assign FLAGS_O     = flags_ff;

endmodule : crs_sequencer

`default_nettype wire

// ==== crs_sequencer_props.sv ====
`timescale 1ns/1ps
`default_nettype none

// bus-level checks of the sequencer, seen from its ports only
module crs_sequencer_props #(
  parameter logic [7:0] OP_CALL_REL = 8'had
) (
  input wire logic        CLK_I,
  input wire logic        NRST_I,
  input wire logic [7:0]  MEM_RDATA_I,
  input wire logic [15:0] MEM_ADDR_O,
  input wire logic [7:0]  MEM_WDATA_O,
  input wire logic        MEM_WE_O,
  input wire logic        MEM_RE_O,
  input wire logic        SYNC_O,
  input wire logic [15:0] PC_O,
  input wire logic [7:0]  SP_O,
  input wire logic [7:0]  ACC_O,
  input wire logic [4:0]  FLAGS_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  ////////////////////////////////////////////////////////////////////////////
  // opcode fetch of one code
  sequence s_op(logic [7:0] op);
    SYNC_O && MEM_RDATA_I == op;
  endsequence
  // two operand reads, one idle build cycle, two pushes
  sequence s_call_body;
    MEM_RE_O && !SYNC_O ##1 MEM_RE_O ##1 !MEM_RE_O && !MEM_WE_O ##1 MEM_WE_O ##1 MEM_WE_O;
  endsequence
  // the saved address is taken at the fetch, so later pc moves cannot hide a slip
  property p_ret_addr;
    logic [15:0] ret;
    (s_op(8'hcd), ret = MEM_ADDR_O + 16'h3) |->
      ##4 MEM_WDATA_O == ret[7:0] ##1 MEM_WDATA_O == ret[15:8];
  endproperty

  ////////////////////////////////////////////////////////////////////////////
  chk_call_cycles: assert property (s_op(8'hcd) |=> s_call_body ##1 SYNC_O)
    else $error("call cycle pattern wrong");
  chk_call_target: assert property (
    s_op(8'hcd) |-> ##1 MEM_ADDR_O == $past(MEM_ADDR_O) + 16'h1
      ##5 MEM_ADDR_O == {$past(MEM_RDATA_I, 5), $past(MEM_RDATA_I, 4)})
    else $error("call target fetch wrong");
  chk_ret_saved: assert property (p_ret_addr)
    else $error("pushed return address wrong");
  chk_push_pair: assert property (
    MEM_WE_O ##1 MEM_WE_O |-> MEM_ADDR_O == $past(MEM_ADDR_O) - 16'h1
      && MEM_ADDR_O[15:8] == 8'h00 ##1 SP_O == $past(MEM_ADDR_O[7:0]) - 8'h1)
    else $error("push order or stack pointer wrong");
  chk_dec_acc: assert property (
    s_op(8'h4a) |-> ##3 SYNC_O && ACC_O == $past(ACC_O, 3) - 8'h1 && !$past(MEM_RE_O))
    else $error("decrement wrong");
  chk_branch_nz: assert property (
    s_op(8'h26) |-> ##3 SYNC_O && MEM_ADDR_O == $past(MEM_ADDR_O, 3) + 16'h2
      + ($past(FLAGS_O[1], 3) ? 16'h0 : 16'($signed($past(MEM_RDATA_I, 2)))))
    else $error("branch target wrong");
  chk_return_walk: assert property (
    s_op(8'h81) |=> !MEM_RE_O ##1 MEM_RE_O && MEM_ADDR_O == {8'h00, $past(SP_O, 2) + 8'h1}
      ##1 !MEM_RE_O ##1 MEM_RE_O && MEM_ADDR_O == {8'h00, $past(SP_O, 4) + 8'h2}
      ##1 !MEM_RE_O ##1 SYNC_O && MEM_ADDR_O == {$past(MEM_RDATA_I, 4), $past(MEM_RDATA_I, 2)})
    else $error("return walk wrong");
  chk_store_dir: assert property (
    s_op(8'hb7) |-> ##3 MEM_WE_O && MEM_ADDR_O == {8'h00, $past(MEM_RDATA_I, 2)}
      && MEM_WDATA_O == ACC_O ##1 SYNC_O)
    else $error("direct store wrong");
  chk_load_flags: assert property (
    s_op(8'ha6) |-> ##2 SYNC_O && ACC_O == $past(MEM_RDATA_I) && FLAGS_O[2] == ACC_O[7]
      && FLAGS_O[1] == (ACC_O == 8'h00) && (FLAGS_O & 5'h19) == ($past(FLAGS_O, 2) & 5'h19))
    else $error("load or flags wrong");
  chk_call_rel: assert property (
    s_op(OP_CALL_REL) |-> ##3 MEM_WE_O ##1 MEM_WE_O ##1 SYNC_O && MEM_ADDR_O ==
      $past(MEM_ADDR_O, 5) + 16'h2 + 16'($signed($past(MEM_RDATA_I, 4))))
    else $error("relative call wrong");
endmodule : crs_sequencer_props

bind crs_sequencer crs_sequencer_props #(.OP_CALL_REL(OP_CALL_REL)) u_props (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .MEM_RDATA_I(MEM_RDATA_I), .MEM_ADDR_O(MEM_ADDR_O),
  .MEM_WDATA_O(MEM_WDATA_O), .MEM_WE_O(MEM_WE_O), .MEM_RE_O(MEM_RE_O), .SYNC_O(SYNC_O),
  .PC_O(PC_O), .SP_O(SP_O), .ACC_O(ACC_O), .FLAGS_O(FLAGS_O));

`default_nettype wire

// ==== crs_mem.sv ====
`timescale 1ns/1ps
`default_nettype none

// program memory and stack ram, zero wait states
module crs_mem (
  input  wire logic        clk_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [7:0]  rdata_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_ff;
  // idle bus shows the inverse of the last byte, so stale data cannot pass
  assign rdata_o = re_i ? mem[addr_i] : ~last_ff;
  // writes land at the edge ending the write cycle
  always @(posedge clk_i) begin
    if (we_i) mem[addr_i] <= wdata_i;
    if (re_i) last_ff <= mem[addr_i];
  end
endmodule : crs_mem

`default_nettype wire

// ==== tb_crs_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_crs_sequencer;
  typedef struct {logic [7:0] val; logic [4:0] flg;} crs_row_t;
  logic        clk = 1'b0;
  logic        nrst_n = 1'b0;
  logic [7:0]  rdata, wdata, sp, acc;
  logic [15:0] addr, pc;
  logic        we, re, sync;
  logic [4:0]  flags;
  int          errors = 0;
  int          comparisons = 0;
  int          ticks = 0;
  int          cyc;
  crs_row_t    rows [5] = '{'{8'h02, 5'h00}, '{8'h80, 5'h04}, '{8'h00, 5'h02},
                            '{8'h7f, 5'h00}, '{8'hff, 5'h04}};

  ////////////////////////////////////////////////////////////////////////////
  crs_sequencer DUT (.CLK_I(clk), .NRST_I(nrst_n), .MEM_RDATA_I(rdata), .MEM_ADDR_O(addr),
    .MEM_WDATA_O(wdata), .MEM_WE_O(we), .MEM_RE_O(re), .SYNC_O(sync), .PC_O(pc),
    .SP_O(sp), .ACC_O(acc), .FLAGS_O(flags));
  crs_mem u_mem (.clk_i(clk), .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
    .rdata_o(rdata));

  // 250 mhz clock
  always #2 clk = ~clk;
  // hang guard, far above the longest program
  always @(posedge clk) begin
    ticks++;
    if (ticks == 3000) begin
      errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_count(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      errors++;
      $display("[FAIL] t=%0t cycles got=%h exp=%h", $time, got, exp);
    end
  endtask : check_count

  // unused space holds a one-cycle no-op so runaway code stays harmless
  task automatic load(input logic [15:0] a, input logic [7:0] b[$]);
    foreach (b[i]) u_mem.mem[a + 16'(i)] = b[i];
  endtask : load

  task automatic clear_mem();
    foreach (u_mem.mem[i]) u_mem.mem[i] = 8'h9d;
  endtask : clear_mem

  // reset three cycles, then count cycles up to the write to waddr
  task automatic run(input logic [15:0] waddr, output int n);
    nrst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 nrst_n = 1'b1;
    n = 1;
    while (!(we === 1'b1 && addr === waddr) && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    #1;
  endtask : run

  task automatic stop_test();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    // load immediate then store direct, one row per value
    foreach (rows[i]) begin
      clear_mem();
      load(16'h0100, '{8'ha6, rows[i].val, 8'hb7, 8'h10});
      run(16'h0010, cyc);
      check_count(cyc, 6);
      check_byte(u_mem.mem[16'h0010], rows[i].val);
      check_byte({3'h0, flags}, {3'h0, rows[i].flg});
      check_byte(acc, rows[i].val);
      $display("load row %0d done", i);
    end
    // outputs while reset is held: opcode fetch already on the bus
    nrst_n = 1'b0;
    #1;
    check_byte({5'h00, sync, re, we}, 8'h06);
    check_byte(sp, 8'hff);
    $display("reset test done");
    // call, count-down loop, return, store
    clear_mem();
    load(16'h0100, '{8'ha6, 8'h02, 8'hcd, 8'h02, 8'h00, 8'hb7, 8'h02});
    load(16'h0200, '{8'h4a, 8'h26, 8'hfd, 8'h81});
    run(16'h0002, cyc);
    check_count(cyc, 30);
    check_byte(u_mem.mem[16'h00ff], 8'h05);
    check_byte(u_mem.mem[16'h00fe], 8'h01);
    check_byte(u_mem.mem[16'h0002], 8'h00);
    check_byte(sp, 8'hff);
    check_byte({3'h0, flags}, 8'h02);
    // fetch after the two-byte store stands at 0107
    check_byte(pc[15:8], 8'h01);
    check_byte(pc[7:0], 8'h07);
    $display("call loop return done");
    // relative call, decrement through zero, return, store
    clear_mem();
    load(16'h0100, '{8'had, 8'h0e, 8'hb7, 8'h20});
    load(16'h0110, '{8'h4a, 8'h81});
    run(16'h0020, cyc);
    // relative call is five cycles: fetch, offset, build, two pushes
    check_count(cyc, 18);
    check_byte(u_mem.mem[16'h00ff], 8'h02);
    check_byte(u_mem.mem[16'h0020], 8'hff);
    check_byte(sp, 8'hff);
    $display("relative call done");
    stop_test();
  end
endmodule : tb_crs_sequencer

`default_nettype wire
